// >>> slot_power_consts.svh
// Offsets, field positions, reset values and timing counts of the slot power block.
`ifndef SLOT_POWER_CONSTS_SVH
`define SLOT_POWER_CONSTS_SVH

`define ADDR_W               8
`define OFS_CTRL             8'h00
`define OFS_INT_STATUS       8'h04
`define OFS_INT_CLEAR        8'h08
`define OFS_INT_ENABLE       8'h0c

`define POS_AUX              0
`define POS_W2B              1
`define POS_WSEL             2
`define POS_RSVD_LO          3
`define POS_RSVD_HI          9
`define POS_OVRD_LO          10
`define POS_OVRD_HI          11
`define POS_VAL_LO           12
`define POS_VAL_HI           19
`define POS_SCALE_LO         20
`define POS_SCALE_HI         21

`define RST_OVRD             2'h0
`define RST_VAL              8'h00
`define RST_SCALE            2'h0
`define RST_WSEL             1'h0
`define RST_W2B              1'h0
`define RST_INT              4'h0

`define EV_EXCESS            0
`define EV_EXT_WAKE          1
`define EV_BEACON            2
`define EV_LOADED            3
`define EV_COUNT             4

`define CLK_MHZ              250
`define WAKE_HOLD_NS         1000
`define WAKE_HOLD_CYC        ((`WAKE_HOLD_NS * `CLK_MHZ + 999) / 1000)

`endif

// >>> slot_power_pkg.sv
// Types shared by the slot power and wake block.
package slot_power_pkg;

  typedef enum logic [1:0] {
    ovrd_ignore,
    ovrd_pin,
    ovrd_pin_ur,
    ovrd_reserved
  } override_t;

  typedef enum logic {
    wake_by_beacon,
    wake_by_pin
  } wake_mode_t;

  typedef enum {
    st_load_wait,
    st_run
  } load_state_t;

endpackage : slot_power_pkg

// >>> pin_sync_if.sv
// Bundle between a pin synchroniser and the logic that uses its clean levels.
`timescale 1ns/1ns
interface pin_sync_if #(parameter int WIDTH = 4);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] clean;
  modport sync (input raw, output clean);
  modport user (output raw, input clean);
endinterface : pin_sync_if

// >>> pin_sync.sv
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ns
module pin_sync #(
  parameter int            WIDTH     = 4,
  parameter logic [31:0]   RST_VALUE = 32'h00000000
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // Pins in, clean levels out
  pin_sync_if.sync         pins
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] mid_reg;
  logic [WIDTH-1:0] late_reg;
  logic [WIDTH-1:0] clean_reg;

  // The first stage feeds only the second; nothing else looks at it.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg  <= RST_VALUE[WIDTH-1:0];
      mid_reg   <= RST_VALUE[WIDTH-1:0];
      late_reg  <= RST_VALUE[WIDTH-1:0];
    end else begin
      meta_reg  <= pins.raw;
      mid_reg   <= meta_reg;
      late_reg  <= mid_reg;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      clean_reg <= RST_VALUE[WIDTH-1:0];
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (mid_reg[i] == late_reg[i]) begin
          clean_reg[i] <= late_reg[i];
        end
      end
    end
  end

  assign pins.clean = clean_reg;

endmodule : pin_sync

// >>> slot_power_wake_control.sv
// Slot power limit override, wake signalling and aux power report of a switch control register.
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/1ns
`include "slot_power_consts.svh"
module slot_power_wake_control #(
  parameter int NUM_PORTS = 4
) (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 reset_n,
  // Reset pins from the board
  input  wire logic                 perst_n,
  input  wire logic                 global_reset_n,
  // Register port
  input  wire logic [`ADDR_W-1:0]   reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_write,
  input  wire logic                 reg_read,
  output logic      [31:0]          reg_rdata,
  // EEPROM loader
  input  wire logic                 eeprom_present,
  input  wire logic                 eeprom_load,
  input  wire logic [21:0]          eeprom_data,
  // Hardware update of the wake bits
  input  wire logic                 hw_wake_update,
  input  wire logic                 hw_wake_signal_select,
  input  wire logic                 hw_wake_pin_to_beacon_enable,
  // Received slot power limit message
  input  wire logic                 slot_limit_valid,
  input  wire logic [7:0]           slot_limit_value,
  input  wire logic [1:0]           slot_limit_scale,
  // Request classification and completion
  input  wire logic                 req_valid,
  input  wire logic                 req_is_config,
  input  wire logic                 req_is_slot_limit,
  output logic                      req_done,
  output logic                      req_unsupported,
  // Wake events and beacon
  input  wire logic                 wake_event,
  output logic                      beacon_request,
  // Open-drain wake pin, active low
  input  wire logic                 wake_pin_n_i,
  output logic                      wake_pin_n_o,
  output logic                      wake_pin_n_oe,
  // Over-power pin and aux power
  output logic                      over_power_indication_pin,
  input  wire logic                 aux_power_detect,
  output logic [NUM_PORTS-1:0]      aux_power_detected,
  // Interrupt
  output logic                      irq
);

  localparam int          HOLD_CYC = (`WAKE_HOLD_CYC < 1) ? 1 : `WAKE_HOLD_CYC;
  localparam logic [31:0] SYNC_RST = 32'h0000000b;

  // Synchronised pins: 0 perst_n, 1 global_reset_n, 2 aux detect, 3 wake pin.
  pin_sync_if #(.WIDTH(4)) pins_if ();

  assign pins_if.raw = {wake_pin_n_i, aux_power_detect, global_reset_n, perst_n};

  pin_sync #(
    .WIDTH     (4),
    .RST_VALUE (SYNC_RST)
  ) u_pin_sync (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .pins    (pins_if)
  );

  logic perst_n_s;
  logic global_reset_n_s;
  logic aux_s;
  logic wake_pin_n_s;

  assign perst_n_s        = pins_if.clean[0];
  assign global_reset_n_s = pins_if.clean[1];
  assign aux_s            = pins_if.clean[2];
  assign wake_pin_n_s     = pins_if.clean[3];

  // Control fields.
  logic [1:0]                 power_override_action_reg;
  logic [7:0]                 min_power_value_reg;
  logic [1:0]                 min_power_scale_reg;
  logic                       wake_signal_select_reg;
  logic                       wake_pin_to_beacon_enable_reg;
  logic                       aux_power_present_reg;
  slot_power_pkg::load_state_t load_state_reg;
  logic                       eeprom_seen_reg;

  logic wr_ctrl;
  logic run;
  logic load_now;

  assign wr_ctrl  = reg_write && (reg_addr == `OFS_CTRL) && run;
  assign run      = (load_state_reg == slot_power_pkg::st_run);
  assign load_now = (load_state_reg == slot_power_pkg::st_load_wait) && eeprom_load;

  // Until the strap is sampled an EEPROM is assumed, so the block never runs early.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      eeprom_seen_reg <= 1'b1;
    end else begin
      eeprom_seen_reg <= eeprom_present;
    end
  end

  // Loading waits for the EEPROM after every reset; without one the block runs at once.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      load_state_reg <= slot_power_pkg::st_load_wait;
    end else begin
      case (load_state_reg)
        slot_power_pkg::st_load_wait: begin
          if ((eeprom_load || !eeprom_seen_reg) && perst_n_s && global_reset_n_s) begin
            load_state_reg <= slot_power_pkg::st_run;
          end
        end
        slot_power_pkg::st_run: begin
          if (!perst_n_s || !global_reset_n_s) begin
            load_state_reg <= slot_power_pkg::st_load_wait;
          end
        end
        default: begin
          load_state_reg <= slot_power_pkg::st_load_wait;
        end
      endcase
    end
  end

  // Power fields follow the fundamental reset pin.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      power_override_action_reg <= `RST_OVRD;
      min_power_value_reg       <= `RST_VAL;
      min_power_scale_reg       <= `RST_SCALE;
    end else if (!perst_n_s) begin
      power_override_action_reg <= `RST_OVRD;
      min_power_value_reg       <= `RST_VAL;
      min_power_scale_reg       <= `RST_SCALE;
    end else if (load_now && eeprom_seen_reg) begin
      power_override_action_reg <= eeprom_data[`POS_OVRD_HI:`POS_OVRD_LO];
      min_power_value_reg       <= eeprom_data[`POS_VAL_HI:`POS_VAL_LO];
      min_power_scale_reg       <= eeprom_data[`POS_SCALE_HI:`POS_SCALE_LO];
    end else if (wr_ctrl) begin
      power_override_action_reg <= reg_wdata[`POS_OVRD_HI:`POS_OVRD_LO];
      min_power_value_reg       <= reg_wdata[`POS_VAL_HI:`POS_VAL_LO];
      min_power_scale_reg       <= reg_wdata[`POS_SCALE_HI:`POS_SCALE_LO];
    end
  end

  // Wake fields follow the global reset pin; hardware updates win over software writes.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wake_signal_select_reg        <= `RST_WSEL;
      wake_pin_to_beacon_enable_reg <= `RST_W2B;
    end else if (!global_reset_n_s) begin
      wake_signal_select_reg        <= `RST_WSEL;
      wake_pin_to_beacon_enable_reg <= `RST_W2B;
    end else if (load_now && eeprom_seen_reg) begin
      wake_signal_select_reg        <= eeprom_data[`POS_WSEL];
      wake_pin_to_beacon_enable_reg <= eeprom_data[`POS_W2B];
    end else if (hw_wake_update) begin
      wake_signal_select_reg        <= hw_wake_signal_select;
      wake_pin_to_beacon_enable_reg <= hw_wake_pin_to_beacon_enable;
    end else if (wr_ctrl) begin
      wake_signal_select_reg        <= reg_wdata[`POS_WSEL];
      wake_pin_to_beacon_enable_reg <= reg_wdata[`POS_W2B];
    end
  end

  // Aux presence is live apart from the synchroniser delay and one further register stage.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      aux_power_present_reg <= 1'b0;
      aux_power_detected    <= '0;
    end else begin
      aux_power_present_reg <= aux_s;
      aux_power_detected    <= {NUM_PORTS{aux_s}};
    end
  end

  // Both figures are in milliwatt units: scale 00 is x1000 down to 11 at x1.
  function automatic logic [17:0] scaled_mw(input logic [7:0] value, input logic [1:0] scale);
    logic [9:0] factor;
    factor = 10'h000;
    case (scale)
      2'h0:    factor = 10'h3e8;
      2'h1:    factor = 10'h064;
      2'h2:    factor = 10'h00a;
      default: factor = 10'h001;
    endcase
    scaled_mw = 18'(value) * 18'(factor);
  endfunction : scaled_mw

  logic [17:0] min_mw;
  logic [17:0] limit_mw;
  logic        over_limit_reg;
  logic        excess;

  assign min_mw   = scaled_mw(min_power_value_reg, min_power_scale_reg);
  assign limit_mw = scaled_mw(slot_limit_value, slot_limit_scale);
  assign excess   = over_limit_reg && (min_power_value_reg != 8'h00);

  // The last message decides; a later message within limits withdraws the override.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      over_limit_reg <= 1'b0;
    end else if (!perst_n_s) begin
      over_limit_reg <= 1'b0;
    end else if (slot_limit_valid && run) begin
      over_limit_reg <= (min_power_value_reg != 8'h00) && (limit_mw > min_mw);
    end
  end

  slot_power_pkg::override_t action;
  logic                      drive_over_power;
  logic                      ur_mode;

  assign action           = slot_power_pkg::override_t'(power_override_action_reg);
  assign drive_over_power = excess && ((action == slot_power_pkg::ovrd_pin) ||
                                       (action == slot_power_pkg::ovrd_pin_ur));
  assign ur_mode          = excess && (action == slot_power_pkg::ovrd_pin_ur);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      over_power_indication_pin <= 1'b0;
    end else begin
      over_power_indication_pin <= drive_over_power;
    end
  end

  // Each request gets its verdict one cycle after it is offered.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      req_done        <= 1'b0;
      req_unsupported <= 1'b0;
    end else begin
      req_done        <= req_valid;
      req_unsupported <= req_valid && ur_mode && !req_is_config && !req_is_slot_limit;
    end
  end

  // Wake signalling.
  slot_power_pkg::wake_mode_t wake_mode;
  logic                       wake_pin_n_s_d;
  logic                       ext_wake;
  logic [15:0]                hold_cnt_reg;

  assign wake_mode = slot_power_pkg::wake_mode_t'(wake_signal_select_reg);

  // Our own drive would look like an external event, so edges are ignored while driving.
  assign ext_wake = wake_pin_n_s_d && !wake_pin_n_s && !wake_pin_n_oe;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wake_pin_n_s_d <= 1'b1;
    end else begin
      wake_pin_n_s_d <= wake_pin_n_s;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      hold_cnt_reg  <= 16'h0000;
      wake_pin_n_oe <= 1'b0;
    end else if (wake_event && run && (wake_mode == slot_power_pkg::wake_by_pin)) begin
      hold_cnt_reg  <= 16'(HOLD_CYC - 1);
      wake_pin_n_oe <= 1'b1;
    end else if (hold_cnt_reg != 16'h0000) begin
      hold_cnt_reg  <= hold_cnt_reg - 16'h0001;
    end else begin
      wake_pin_n_oe <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wake_pin_n_o <= 1'b1;
    end else begin
      wake_pin_n_o <= 1'b0;
    end
  end

  logic beacon_next;

  assign beacon_next = run && (wake_mode == slot_power_pkg::wake_by_beacon) &&
                       (wake_event ||
                        (ext_wake && wake_pin_to_beacon_enable_reg));

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      beacon_request <= 1'b0;
    end else begin
      beacon_request <= beacon_next;
    end
  end

  // Interrupt status: hardware sets win over a clear in the same cycle.
  logic [`EV_COUNT-1:0] int_status_reg;
  logic [`EV_COUNT-1:0] int_enable_reg;
  logic [`EV_COUNT-1:0] events;
  logic [`EV_COUNT-1:0] clear_mask;
  logic                 excess_d;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      excess_d <= 1'b0;
    end else begin
      excess_d <= excess;
    end
  end

  assign events[`EV_EXCESS]   = excess && !excess_d;
  assign events[`EV_EXT_WAKE] = ext_wake;
  assign events[`EV_BEACON]   = beacon_next;
  assign events[`EV_LOADED]   = load_now;
  assign clear_mask = (reg_write && (reg_addr == `OFS_INT_CLEAR)) ? reg_wdata[`EV_COUNT-1:0] : '0;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      int_status_reg <= `RST_INT;
    end else begin
      int_status_reg <= (int_status_reg & ~clear_mask) | events;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      int_enable_reg <= `RST_INT;
    end else if (reg_write && (reg_addr == `OFS_INT_ENABLE)) begin
      int_enable_reg <= reg_wdata[`EV_COUNT-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((int_status_reg & ~clear_mask) | events) & int_enable_reg);
    end
  end

  // Register reads; data stands only in the cycle after the strobe.
  logic [31:0] ctrl_view;

  always_comb begin
    ctrl_view                                = 32'h00000000;
    ctrl_view[`POS_SCALE_HI:`POS_SCALE_LO]   = min_power_scale_reg;
    ctrl_view[`POS_VAL_HI:`POS_VAL_LO]       = min_power_value_reg;
    ctrl_view[`POS_OVRD_HI:`POS_OVRD_LO]     = power_override_action_reg;
    ctrl_view[`POS_RSVD_HI:`POS_RSVD_LO]     = 7'h00;
    ctrl_view[`POS_WSEL]                     = wake_signal_select_reg;
    ctrl_view[`POS_W2B]                      = wake_pin_to_beacon_enable_reg;
    ctrl_view[`POS_AUX]                      = aux_power_present_reg;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_read) begin
      case (reg_addr)
        `OFS_CTRL:       reg_rdata <= ctrl_view;
        `OFS_INT_STATUS: reg_rdata <= {{(32-`EV_COUNT){1'b0}}, int_status_reg};
        `OFS_INT_ENABLE: reg_rdata <= {{(32-`EV_COUNT){1'b0}}, int_enable_reg};
        default:         reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule : slot_power_wake_control

// >>> slot_power_checker.sv
// Concurrent checks on the ports of the slot power block.
`timescale 1ns/1ns
`include "slot_power_consts.svh"
module slot_power_checker #(
  parameter int NUM_PORTS = 4
) (
  // Clock and reset
  input wire logic                 ref_clk,
  input wire logic                 reset_n,
  // Register port
  input wire logic [`ADDR_W-1:0]   reg_addr,
  input wire logic                 reg_read,
  input wire logic [31:0]          reg_rdata,
  // Slot limit and requests
  input wire logic                 slot_limit_valid,
  input wire logic                 req_valid,
  input wire logic                 req_is_config,
  input wire logic                 req_is_slot_limit,
  input wire logic                 req_done,
  input wire logic                 req_unsupported,
  // Pins
  input wire logic                 wake_pin_n_o,
  input wire logic                 wake_pin_n_oe,
  input wire logic                 over_power_indication_pin,
  input wire logic [NUM_PORTS-1:0] aux_power_detected
);
  localparam int HOLD = `WAKE_HOLD_CYC;
  int unsigned oe_cnt;

  // Cycles the wake pin has been driven.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) oe_cnt <= 0;
    else oe_cnt <= wake_pin_n_oe ? oe_cnt + 1 : 0;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  property p_done; req_valid |=> req_done; endproperty
  a_done: assert property (p_done) else $error("request not completed");
  property p_exempt; req_valid && (req_is_config || req_is_slot_limit) |=> !req_unsupported; endproperty
  a_exempt: assert property (p_exempt) else $error("exempt request refused");
  property p_ur_pin; req_unsupported |-> over_power_indication_pin || $past(over_power_indication_pin); endproperty
  a_ur_pin: assert property (p_ur_pin) else $error("refusal without over-power pin");
  property p_pin_cause; $rose(over_power_indication_pin) |-> $past(slot_limit_valid, 2); endproperty
  a_pin_cause: assert property (p_pin_cause) else $error("over-power pin rose without message");
  property p_rsvd;
    reg_read && reg_addr == `OFS_CTRL |=> reg_rdata[9:3] == 7'h00 && reg_rdata[31:22] == 10'h000;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved control bits not zero");
  property p_aux; aux_power_detected == {NUM_PORTS{aux_power_detected[0]}}; endproperty
  a_aux: assert property (p_aux) else $error("ports disagree on aux power");
  property p_oe_low; wake_pin_n_oe |-> !wake_pin_n_o; endproperty
  a_oe_low: assert property (p_oe_low) else $error("wake pin driven high");
  property p_hold_max; oe_cnt <= HOLD; endproperty
  a_hold_max: assert property (p_hold_max) else $error("wake pin held too long");
  property p_hold_end; $fell(wake_pin_n_oe) |-> oe_cnt == HOLD; endproperty
  a_hold_end: assert property (p_hold_end) else $error("wake pin released early");
endmodule : slot_power_checker

// >>> slot_power_link_partner.sv
// Upstream link partner sending slot limit messages and requests.
`timescale 1ns/1ns
module slot_power_link_partner (
  // Clock
  input  wire logic ref_clk,
  // Slot power limit message
  output logic       slot_limit_valid,
  output logic [7:0] slot_limit_value,
  output logic [1:0] slot_limit_scale,
  // Requests
  output logic       req_valid,
  output logic       req_is_config,
  output logic       req_is_slot_limit
);
  initial begin
    {slot_limit_valid, slot_limit_value, slot_limit_scale, req_valid, req_is_config, req_is_slot_limit} = '0;
  end

  // Released qualifiers are inverted so stale values never look live.
  task automatic send_limit(input logic [7:0] v, input logic [1:0] s);
    @(posedge ref_clk);
    slot_limit_valid <= 1'b1;
    slot_limit_value <= v;
    slot_limit_scale <= s;
    @(posedge ref_clk);
    slot_limit_valid <= 1'b0;
    slot_limit_value <= ~v;
    slot_limit_scale <= ~s;
  endtask : send_limit

  task automatic send_req(input logic cfg, input logic slot);
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_is_config <= cfg;
    req_is_slot_limit <= slot;
    @(posedge ref_clk);
    req_valid <= 1'b0;
    req_is_config <= ~cfg;
    req_is_slot_limit <= ~slot;
  endtask : send_req
endmodule : slot_power_link_partner

// >>> slot_power_wake_control_tb_top.sv
// Self-checking bench for the slot power block.
`timescale 1ns/1ns
`include "slot_power_consts.svh"
module slot_power_wake_control_tb_top;
  logic        ref_clk = 1'b0, reset_n = 1'b0, perst_n = 1'b1, global_reset_n = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
  logic        reg_write = 1'b0, reg_read = 1'b0, eeprom_present = 1'b0, eeprom_load = 1'b0;
  logic [21:0] eeprom_data = 22'h0;
  logic        hw_wake_update = 1'b0, hw_wake_signal_select = 1'b0, hw_wake_pin_to_beacon_enable = 1'b0;
  logic        slot_limit_valid, req_valid, req_is_config, req_is_slot_limit, req_done, req_unsupported;
  logic [7:0]  slot_limit_value;
  logic [1:0]  slot_limit_scale;
  logic        wake_event = 1'b0, beacon_request, ext_wake_n = 1'b1, wake_pin_n_o, wake_pin_n_oe;
  logic        over_power_indication_pin, aux_power_detect = 1'b1, irq;
  logic [3:0]  aux_power_detected;
  int          fail_count = 0, n_tests = 0;
  int unsigned mv, ms, v, s;
  // The wake line is open drain with a pull-up: low while anyone pulls it.
  wire         wake_wire_n = ext_wake_n & ~wake_pin_n_oe;

  always #2 ref_clk = ~ref_clk;

  slot_power_wake_control slot_power_wake_control_inst (.wake_pin_n_i(wake_wire_n), .*);
  slot_power_link_partner slot_power_link_partner_inst (.*);

  task automatic test_done;
    if (fail_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= wd;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] rdv);
    @(posedge ref_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1 rdv = reg_rdata;
  endtask : rd

  function automatic logic [31:0] ctrl(input logic [1:0] sc, input logic [7:0] val, input logic [1:0] ov,
                                       input logic ws, input logic wb);
    return {10'h0, sc, val, ov, 7'h0, ws, wb, 1'b0};
  endfunction : ctrl

  // Thousandths of the base unit, so all scales compare exactly.
  function automatic int unsigned milli(input logic [7:0] val, input logic [1:0] sc);
    return val * (sc == 2'h0 ? 1000 : sc == 2'h1 ? 100 : sc == 2'h2 ? 10 : 1);
  endfunction : milli

  task automatic chk_ctrl(input logic [31:0] exp, input string what);
    logic [31:0] got;
    rd(`OFS_CTRL, got);
    chk(what, exp | {31'h0, aux_power_detect}, got);
  endtask : chk_ctrl

  task automatic limit(input logic [7:0] val, input logic [1:0] sc, input logic exp);
    slot_power_link_partner_inst.send_limit(val, sc);
    repeat (2) @(posedge ref_clk);
    #1 chk("over_power_indication_pin", {31'h0, exp}, {31'h0, over_power_indication_pin});
  endtask : limit

  task automatic req(input logic cfg, input logic slot, input logic exp);
    slot_power_link_partner_inst.send_req(cfg, slot);
    #1 chk("req_done", 32'h1, {31'h0, req_done});
    chk("req_unsupported", {31'h0, exp}, {31'h0, req_unsupported});
  endtask : req

  task automatic wake;
    @(posedge ref_clk);
    wake_event <= 1'b1;
    @(posedge ref_clk);
    wake_event <= 1'b0;
    #1;
  endtask : wake

  task automatic ext_wake(input logic exp);
    logic seen = 1'b0;
    repeat (6) @(posedge ref_clk);
    ext_wake_n <= 1'b0;
    repeat (10) begin
      @(posedge ref_clk);
      #1 seen |= beacon_request;
    end
    ext_wake_n <= 1'b1;
    chk("external wake beacon", {31'h0, exp}, {31'h0, seen});
  endtask : ext_wake

  task automatic pulse_rst(input logic fund);
    if (fund) perst_n <= 1'b0;
    else global_reset_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    perst_n <= 1'b1;
    global_reset_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
  endtask : pulse_rst

  initial begin
    void'($urandom(32'h1fa0ba7a));
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk_ctrl(32'h0, "control after reset");
    rd(8'h10, d);
    chk("unmapped read", 32'h0, d);
    d = ctrl(2'h1, 8'ha5, 2'h2, 1'b1, 1'b1);
    wr(`OFS_CTRL, d | 32'hffc003f9);
    chk_ctrl(d, "control fields");
    aux_power_detect <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk_ctrl(d, "aux absent");
    chk("aux_power_detected", 32'h0, {28'h0, aux_power_detected});
    aux_power_detect <= 1'b1;
    for (int ov = 0; ov < 3; ov++) begin
      wr(`OFS_CTRL, ctrl(2'h0, 8'h10, ov[1:0], 1'b0, 1'b0));
      limit(8'h20, 2'h0, ov != 0);
      req(1'b1, 1'b0, 1'b0);
      req(1'b0, 1'b1, 1'b0);
      req(1'b0, 1'b0, ov == 2);
      limit(8'h10, 2'h0, 1'b0);
    end
    wr(`OFS_CTRL, ctrl(2'h0, 8'h00, 2'h1, 1'b0, 1'b0));
    limit(8'hff, 2'h0, 1'b0);
    repeat (24) begin
      mv = $urandom_range(255, 1);
      ms = $urandom_range(3, 0);
      v = $urandom_range(255, 0);
      s = $urandom_range(3, 0);
      limit(8'h00, 2'h0, 1'b0);
      wr(`OFS_CTRL, ctrl(ms[1:0], mv[7:0], 2'h1, 1'b0, 1'b0));
      limit(v[7:0], s[1:0], milli(v[7:0], s[1:0]) > milli(mv[7:0], ms[1:0]));
    end
    limit(8'h00, 2'h0, 1'b0);
    wr(`OFS_CTRL, ctrl(2'h0, 8'h00, 2'h0, 1'b0, 1'b0));
    wake;
    chk("beacon_request", 32'h1, {31'h0, beacon_request});
    chk("wake_pin_n_oe", 32'h0, {31'h0, wake_pin_n_oe});
    wr(`OFS_CTRL, ctrl(2'h0, 8'h00, 2'h0, 1'b1, 1'b1));
    wake;
    chk("beacon_request", 32'h0, {31'h0, beacon_request});
    repeat (`WAKE_HOLD_CYC - 1) @(posedge ref_clk);
    #1 chk("wake_pin_n_oe", 32'h1, {31'h0, wake_pin_n_oe});
    @(posedge ref_clk);
    #1 chk("wake_pin_n_oe", 32'h0, {31'h0, wake_pin_n_oe});
    ext_wake(1'b0);
    wr(`OFS_CTRL, ctrl(2'h0, 8'h00, 2'h0, 1'b0, 1'b1));
    ext_wake(1'b1);
    wr(`OFS_CTRL, ctrl(2'h0, 8'h00, 2'h0, 1'b0, 1'b0));
    ext_wake(1'b0);
    wr(`OFS_INT_CLEAR, 32'hf);
    wr(`OFS_INT_ENABLE, 32'h4);
    #1 chk("irq", 32'h0, {31'h0, irq});
    wake;
    repeat (2) @(posedge ref_clk);
    #1 chk("irq", 32'h1, {31'h0, irq});
    rd(`OFS_INT_STATUS, d);
    chk("interrupt status", 32'h4, d & 32'h4);
    wr(`OFS_INT_CLEAR, 32'h4);
    repeat (2) @(posedge ref_clk);
    #1 chk("irq", 32'h0, {31'h0, irq});
    wr(`OFS_INT_ENABLE, 32'h0);
    wake;
    repeat (2) @(posedge ref_clk);
    #1 chk("irq", 32'h0, {31'h0, irq});
    @(posedge ref_clk);
    hw_wake_update <= 1'b1;
    hw_wake_signal_select <= 1'b1;
    hw_wake_pin_to_beacon_enable <= 1'b1;
    @(posedge ref_clk);
    hw_wake_update <= 1'b0;
    chk_ctrl(ctrl(2'h0, 8'h00, 2'h0, 1'b1, 1'b1), "hardware update");
    wr(`OFS_CTRL, ctrl(2'h3, 8'h7e, 2'h1, 1'b1, 1'b1));
    pulse_rst(1'b1);
    chk_ctrl(ctrl(2'h0, 8'h00, 2'h0, 1'b1, 1'b1), "after fundamental reset");
    pulse_rst(1'b0);
    chk_ctrl(32'h0, "after global reset");
    eeprom_present <= 1'b1;
    pulse_rst(1'b1);
    wr(`OFS_CTRL, ctrl(2'h0, 8'h33, 2'h1, 1'b0, 1'b0));
    chk_ctrl(32'h0, "write before load");
    d = ctrl(2'h2, 8'h44, 2'h2, 1'b1, 1'b0);
    @(posedge ref_clk);
    eeprom_load <= 1'b1;
    eeprom_data <= d[21:0];
    @(posedge ref_clk);
    eeprom_load <= 1'b0;
    eeprom_data <= ~d[21:0];
    chk_ctrl(d, "eeprom load");
    test_done;
  end

  // A hang is declared after twenty thousand cycles.
  initial begin
    #80000;
    fail_count++;
    test_done;
  end
endmodule : slot_power_wake_control_tb_top

bind slot_power_wake_control slot_power_checker #(.NUM_PORTS(NUM_PORTS)) slot_power_checker_inst (.*);
